// >>> verilog/fsa_pkg.sv
// package: constants, types and register map of the program flash self-access block
// Functional notes
// - a table read hands the core one byte, never a whole word.
// - a table read copies the byte at the pointer into the latch.
// - flash is word organised; pointer bit 0 picks high or low byte.
// - an erase always clears a whole 64-byte row, never one word.
// - erase row comes from pointer bits 21..6; bits 5..0 are ignored.
// - a long write halts the core until the internal timer expires.
// - after start for an erase the core stalls for the timed interval.
// - programming works on whole 64-byte rows only.
// - 64 byte-wide holding registers, loaded by table writes, feed programming.
// - a table write only updates a holding register and never stalls.
// - holding registers return to FFh on reset and after writes; FFh changes nothing.
// - programming without erase only clears bits, never sets one.
// - programming with only some holding registers loaded is accepted.
// - erase and program duration comes from an on-chip timer.
// - table operations keep, post-increment, post-decrement or pre-increment the pointer.
// - only software sets start; hardware clears it at completion.
// - a cycle cut short by reset or an improper attempt sets the error flag.
package fsa_pkg;
	localparam int PTR_W     = 22;
	localparam int ROW_LSB   = 6;
	localparam int HOLD_N    = 64;
	localparam int ROW_WORDS = 32;
	localparam int DEF_ROWS  = 8;

	localparam logic [7:0] OFF_PTR    = 8'h00;
	localparam logic [7:0] OFF_LATCH  = 8'h04;
	localparam logic [7:0] OFF_CTRL   = 8'h08;
	localparam logic [7:0] OFF_UNLOCK = 8'h0c;
	localparam logic [7:0] OFF_TBL_OP = 8'h10;

	localparam logic [7:0]  KEY_FIRST   = 8'h55;
	localparam logic [7:0]  KEY_SECOND  = 8'haa;
	localparam logic [7:0]  ERASED_BYTE = 8'hff;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [21:0] PTR_RESET   = 22'h000000;
	localparam logic [7:0]  LATCH_RESET = 8'h00;

	localparam int BIT_PGM   = 7;
	localparam int BIT_CFG   = 6;
	localparam int BIT_ERASE = 4;
	localparam int BIT_ERR   = 3;
	localparam int BIT_WRITE_ENABLE_BIT  = 2;
	localparam int BIT_START = 1;
	localparam int BIT_OP_WR = 0;
	localparam int MODE_LSB  = 1;

	localparam int WRITE_TIME_NS     = 1000000;
	localparam int CLK_PERIOD_NS     = 25;
	localparam int LONG_WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {TBL_KEEP, TBL_POST_INC, TBL_POST_DEC, TBL_PRE_INC} tbl_mode_t;
	typedef enum logic {ST_IDLE, ST_LONG} state_t;
	typedef enum logic [1:0] {UL_NONE, UL_FIRST, UL_ARMED} unlock_t;

	typedef struct packed {
		logic pgm_sel;
		logic cfg_sel;
		logic erase_sel;
		logic err;
		logic write_enable_bit;
		logic start;
	} ctrl_t;

	typedef struct packed {
		logic        commit;
		logic        erase;
		logic [15:0] row;
	} flash_cmd_t;

	localparam ctrl_t CTRL_RESET = '0;
endpackage

// >>> verilog/flash_row_array.sv
// module: word-organised program flash array with row erase and row program
`timescale 1ns/100ps
module flash_row_array #(
	parameter int ROW_BITS = fsa_pkg::DEF_ROWS
)(
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire fsa_pkg::flash_cmd_t            cmd,
	input  wire logic [8*fsa_pkg::HOLD_N-1:0]   wr_bytes,
	input  wire logic [ROW_BITS+5:0]            rd_addr,
	output logic [7:0]                          rd_byte
);
	localparam int WA = ROW_BITS + 5;

	logic [15:0]   mem [2**WA];
	logic [15:0]   rd_word;
	logic [WA-1:0] first_w;

	if (ROW_BITS < 1 || ROW_BITS > 16)
	begin : g_bad_rows
		$error("ROW_BITS must lie in 1..16");
	end

	assign rd_word = mem[rd_addr[WA:1]];
	assign rd_byte = rd_addr[0] ? rd_word[15:8] : rd_word[7:0];
	assign first_w = {cmd.row[ROW_BITS-1:0], 5'h00};

	// a commit touches all 32 words of the row at once
	always_ff @(posedge pclk)
	begin
		if (cmd.commit)
		begin
			for (int i = 0; i < fsa_pkg::ROW_WORDS; i++)
			begin
				if (cmd.erase)
					mem[{cmd.row[ROW_BITS-1:0], 5'(i)}] <= fsa_pkg::ERASED_WORD;
				else
					mem[{cmd.row[ROW_BITS-1:0], 5'(i)}] <=
						mem[{cmd.row[ROW_BITS-1:0], 5'(i)}] & wr_bytes[16*i +: 16];
			end
		end
	end

	property p_erase_ones;
		@(posedge pclk) disable iff (!presetn)
		cmd.commit && cmd.erase |=> mem[$past(first_w)] == fsa_pkg::ERASED_WORD;
	endproperty
	a_erase_ones: assert property (p_erase_ones) else $error("erased word not all ones");

	property p_only_clears;
		@(posedge pclk) disable iff (!presetn)
		cmd.commit && !cmd.erase |=> (mem[$past(first_w)] & ~$past(mem[first_w])) == 16'h0000;
	endproperty
	a_only_clears: assert property (p_only_clears) else $error("program set a bit");
endmodule

// >>> verilog/flash_self_ctrl.sv
// module: program flash self-access controller with an apb register slave
`timescale 1ns/100ps
module flash_self_ctrl #(
	parameter int ROW_BITS    = fsa_pkg::DEF_ROWS,
	parameter int LONG_CYCLES = fsa_pkg::LONG_WRITE_CYCLES
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        warm_reset,
	output logic             core_stall
);
	localparam int TW = $clog2(LONG_CYCLES + 1);
	localparam int FA = ROW_BITS + fsa_pkg::ROW_LSB;
	localparam int HN = fsa_pkg::HOLD_N;

	if (ROW_BITS < 1 || ROW_BITS > 16)
	begin : g_bad_rows
		$error("ROW_BITS must lie in 1..16");
	end
	if (LONG_CYCLES < 2)
	begin : g_bad_long
		$error("LONG_CYCLES must be at least 2");
	end

	fsa_pkg::state_t     state;
	fsa_pkg::state_t     next_state;
	fsa_pkg::unlock_t    unlock;
	fsa_pkg::unlock_t    next_unlock;
	fsa_pkg::ctrl_t      ctrl;
	fsa_pkg::ctrl_t      next_ctrl;
	fsa_pkg::tbl_mode_t  tbl_mode;
	fsa_pkg::flash_cmd_t cmd;
	logic [21:0]         ptr;
	logic [21:0]         next_ptr;
	logic [21:0]         eff_addr;
	logic [7:0]          latch;
	logic [7:0]          hold [HN];
	logic [8*HN-1:0]     hold_flat;
	logic                hold_all_ones;
	logic [TW-1:0]       timer;
	logic [TW-1:0]       next_timer;
	logic [TW-1:0]       stall_len;
	logic                erase_q;
	logic [15:0]         row_q;
	logic                done_q;
	logic [7:0]          rd_byte;
	logic [31:0]         rd_mux;
	logic                acc;
	logic                wr;
	logic                sel_ptr;
	logic                sel_latch;
	logic                sel_ctrl;
	logic                sel_unlock;
	logic                sel_op;
	logic                hit;
	logic                tbl_go;
	logic                tbl_write;
	logic                start_req;
	logic                start_ok;
	logic                refused;
	logic                finish;
	logic                abort;

	// only the low 21 pointer bits move; bit 21 stays put
	function automatic logic [21:0] step(input logic [21:0] p, input logic down);
		step = {p[21], down ? p[20:0] - 21'h000001 : p[20:0] + 21'h000001};
	endfunction

	// apb decode; no access completes while a long write runs
	assign acc        = psel && penable && pready;
	assign wr         = acc && pwrite;
	assign sel_ptr    = paddr == fsa_pkg::OFF_PTR;
	assign sel_latch  = paddr == fsa_pkg::OFF_LATCH;
	assign sel_ctrl   = paddr == fsa_pkg::OFF_CTRL;
	assign sel_unlock = paddr == fsa_pkg::OFF_UNLOCK;
	assign sel_op     = paddr == fsa_pkg::OFF_TBL_OP;
	assign hit        = sel_ptr || sel_latch || sel_ctrl || sel_unlock || sel_op;
	assign pready     = (state == fsa_pkg::ST_IDLE) && !done_q;
	assign pslverr    = acc && !hit;
	assign core_stall = state == fsa_pkg::ST_LONG;

	// table operations
	assign tbl_go    = wr && sel_op;
	assign tbl_write = pwdata[fsa_pkg::BIT_OP_WR];
	assign tbl_mode  = fsa_pkg::tbl_mode_t'(pwdata[fsa_pkg::MODE_LSB +: 2]);
	assign eff_addr  = (tbl_mode == fsa_pkg::TBL_PRE_INC) ? step(ptr, 1'b0) : ptr;
	assign next_ptr  = (wr && sel_ptr) ? pwdata[21:0]
		: (!tbl_go || tbl_mode == fsa_pkg::TBL_KEEP) ? ptr
		: step(ptr, tbl_mode == fsa_pkg::TBL_POST_DEC);

	// start checks: unlock must be the writes just before, enable set, flash selected
	assign start_req = wr && sel_ctrl && pwdata[fsa_pkg::BIT_START];
	assign start_ok  = start_req && unlock == fsa_pkg::UL_ARMED && pwdata[fsa_pkg::BIT_WRITE_ENABLE_BIT]
		&& pwdata[fsa_pkg::BIT_PGM] && !pwdata[fsa_pkg::BIT_CFG];
	assign refused   = start_req && !start_ok;
	assign finish    = core_stall && timer == TW'(LONG_CYCLES - 1) && !warm_reset;
	assign abort     = core_stall && warm_reset;
	assign cmd       = '{commit: finish, erase: erase_q, row: row_q};

	always_comb
	begin
		next_unlock = unlock;
		if (warm_reset)
			next_unlock = fsa_pkg::UL_NONE;
		else if (wr)
		begin
			if (sel_unlock && pwdata[7:0] == fsa_pkg::KEY_FIRST)
				next_unlock = fsa_pkg::UL_FIRST;
			else if (sel_unlock && pwdata[7:0] == fsa_pkg::KEY_SECOND
				&& unlock == fsa_pkg::UL_FIRST)
				next_unlock = fsa_pkg::UL_ARMED;
			else
				next_unlock = fsa_pkg::UL_NONE;
		end
	end

	always_comb
	begin
		next_ctrl = ctrl;
		if (wr && sel_ctrl)
		begin
			next_ctrl.pgm_sel   = pwdata[fsa_pkg::BIT_PGM];
			next_ctrl.cfg_sel   = pwdata[fsa_pkg::BIT_CFG];
			next_ctrl.erase_sel = pwdata[fsa_pkg::BIT_ERASE];
			next_ctrl.err       = pwdata[fsa_pkg::BIT_ERR];
			next_ctrl.write_enable_bit      = pwdata[fsa_pkg::BIT_WRITE_ENABLE_BIT];
			next_ctrl.start     = ctrl.start || start_ok;
		end
		if (finish)
		begin
			next_ctrl.start     = 1'b0;
			next_ctrl.erase_sel = 1'b0;
			next_ctrl.err       = 1'b0;
		end
		if (abort)
			next_ctrl.start = 1'b0;
		// a hardware set beats a software clear in the same cycle
		if (start_ok || refused || abort)
			next_ctrl.err = 1'b1;
	end

	always_comb
	begin
		next_state = state;
		next_timer = timer;
		case (state)
			fsa_pkg::ST_IDLE:
			begin
				next_timer = '0;
				if (start_ok)
					next_state = fsa_pkg::ST_LONG;
			end
			fsa_pkg::ST_LONG:
			begin
				next_timer = timer + TW'(1);
				if (finish || abort)
				begin
					next_state = fsa_pkg::ST_IDLE;
					next_timer = '0;
				end
			end
			default:
			begin
				next_state = fsa_pkg::ST_IDLE;
				next_timer = '0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state  <= fsa_pkg::ST_IDLE;
			timer  <= '0;
			unlock <= fsa_pkg::UL_NONE;
			ctrl   <= fsa_pkg::CTRL_RESET;
			ptr    <= fsa_pkg::PTR_RESET;
			done_q <= 1'b0;
		end
		else
		begin
			state  <= next_state;
			timer  <= next_timer;
			unlock <= next_unlock;
			ctrl   <= next_ctrl;
			ptr    <= next_ptr;
			done_q <= finish || abort;
		end
	end

	// row and kind are frozen when the cycle starts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			erase_q <= 1'b0;
			row_q   <= '0;
		end
		else if (start_ok)
		begin
			erase_q <= pwdata[fsa_pkg::BIT_ERASE];
			row_q   <= ptr[21:fsa_pkg::ROW_LSB];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			latch <= fsa_pkg::LATCH_RESET;
		else if (tbl_go && !tbl_write)
			latch <= rd_byte;
		else if (wr && sel_latch)
			latch <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int k = 0; k < HN; k++)
				hold[k] <= fsa_pkg::ERASED_BYTE;
		else if (finish || warm_reset)
			for (int k = 0; k < HN; k++)
				hold[k] <= fsa_pkg::ERASED_BYTE;
		else if (tbl_go && tbl_write)
			hold[eff_addr[5:0]] <= latch;
	end

	// unloaded bytes stay all ones and leave flash alone
	always_comb
	begin
		hold_all_ones = 1'b1;
		for (int k = 0; k < HN; k++)
		begin
			hold_flat[8*k +: 8] = hold[k];
			hold_all_ones = hold_all_ones && hold[k] == fsa_pkg::ERASED_BYTE;
		end
	end

	flash_row_array #(
		.ROW_BITS (ROW_BITS)
	) u_array (
		.pclk     (pclk),
		.presetn  (presetn),
		.cmd      (cmd),
		.wr_bytes (hold_flat),
		.rd_addr  (eff_addr[FA-1:0]),
		.rd_byte  (rd_byte)
	);

	assign rd_mux = sel_ptr ? {10'h000, ptr}
		: sel_latch ? {24'h000000, latch}
		: sel_ctrl ? {24'h000000, ctrl.pgm_sel, ctrl.cfg_sel, 1'b0, ctrl.erase_sel,
			ctrl.err, ctrl.write_enable_bit, ctrl.start, 1'b0}
		: 32'h00000000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel)
			prdata <= rd_mux;
	end

	// helper for checking the timed length independently of the timer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stall_len <= '0;
		else if (core_stall)
			stall_len <= stall_len + TW'(1);
		else
			stall_len <= '0;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_stalled;
		(core_stall && !pready) [*8];
	endsequence

	property p_stall_after_start;
		start_ok |=> s_stalled;
	endproperty
	a_stall_after_start: assert property (p_stall_after_start) else $error("no stall");

	property p_stall_holds;
		core_stall && !warm_reset && timer < TW'(LONG_CYCLES - 1) |=> core_stall;
	endproperty
	a_stall_holds: assert property (p_stall_holds) else $error("stall ended early");

	property p_timed_len;
		$fell(core_stall) && !$past(warm_reset) |-> $past(stall_len) == TW'(LONG_CYCLES - 1);
	endproperty
	a_timed_len: assert property (p_timed_len) else $error("long write length wrong");

	property p_row_frozen;
		start_ok |=> row_q == $past(ptr[21:6]) && erase_q == $past(pwdata[4]);
	endproperty
	a_row_frozen: assert property (p_row_frozen) else $error("row not taken from pointer");

	property p_tbl_write_short;
		tbl_go && tbl_write |-> !core_stall ##1 !core_stall && pready;
	endproperty
	a_tbl_write_short: assert property (p_tbl_write_short) else $error("table write stalled");

	property p_read_byte;
		tbl_go && !tbl_write |=> latch == $past(rd_byte);
	endproperty
	a_read_byte: assert property (p_read_byte) else $error("latch not loaded");

	property p_post_dec;
		tbl_go && tbl_mode == fsa_pkg::TBL_POST_DEC |=> ptr == step($past(ptr), 1'b1);
	endproperty
	a_post_dec: assert property (p_post_dec) else $error("pointer not decremented");

	property p_hold_cleared;
		$fell(core_stall) |-> hold_all_ones && !ctrl.start;
	endproperty
	a_hold_cleared: assert property (p_hold_cleared) else $error("holding not cleared");

	property p_start_cleared;
		finish |=> !ctrl.start && !ctrl.err ##1 pready;
	endproperty
	a_start_cleared: assert property (p_start_cleared) else $error("start not cleared");

	property p_refused;
		refused |=> !core_stall && ctrl.err && !ctrl.start;
	endproperty
	a_refused: assert property (p_refused) else $error("bad start accepted");

	property p_abort_err;
		abort |=> ctrl.err && !core_stall && hold_all_ones;
	endproperty
	a_abort_err: assert property (p_abort_err) else $error("abort not flagged");
endmodule

// >>> dv/core_model.sv
// partner: processor core issuing apb transfers and unlock sequences
`timescale 1ns/100ps
module core_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	int   timeouts;
	logic last_err;

	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// pready, pslverr and read data are all sampled at the same rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 5000);
		if (pready !== 1'b1)
			timeouts++;
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	task automatic launch(input logic erase, input logic [7:0] key2, input logic write_enable_bit);
		logic [31:0] q;
		xfer(1'b1, 8'h08, {24'h0, 3'b100, erase, 1'b0, write_enable_bit, 2'b00}, q);
		xfer(1'b1, 8'h0c, {24'h0, fsa_pkg::KEY_FIRST}, q);
		xfer(1'b1, 8'h0c, {24'h0, key2}, q);
		xfer(1'b1, 8'h08, {24'h0, 3'b100, erase, 1'b0, write_enable_bit, 2'b10}, q);
	endtask
endmodule

// >>> dv/tb_program_flash_self_access.sv
// testbench: self-checking run of the program flash self-access controller
`timescale 1ns/100ps
module tb_program_flash_self_access;
	localparam int LC = 20;
	localparam int RB = 2;
	logic        pclk;
	logic        presetn;
	logic        warm_reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        core_stall;
	logic [31:0] q;
	int          fail_count;
	int          compares;
	int          stall_len;
	int          stall_run;
	int          ptr;
	int          latch;
	int          seed;
	int          mem [256];
	int          hold [64];

	flash_self_ctrl #(
		.ROW_BITS   (RB),
		.LONG_CYCLES(LC)
	) DUT (
		.pclk       (pclk),
		.presetn    (presetn),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.warm_reset (warm_reset),
		.core_stall (core_stall)
	);

	core_model core (
		.pclk    (pclk),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// length of the last stall burst in clock cycles
	always @(posedge pclk)
	begin
		if (core_stall === 1'b1)
			stall_run <= stall_run + 1;
		else if (stall_run != 0)
		begin
			stall_len <= stall_run;
			stall_run <= 0;
		end
	end

	task automatic close_out();
		fail_count += core.timeouts;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		core.xfer(wr, a, d, q);
		if (core.timeouts != 0)
			close_out();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(q, exp);
	endtask

	task automatic setp(input int v);
		bus(1'b1, 8'h00, 32'(v));
		ptr = v;
	endtask

	task automatic setl(input int v);
		bus(1'b1, 8'h04, 32'(v));
		latch = v;
	endtask

	// only the low 21 pointer bits move
	function automatic int step(input int p, input int d);
		return (p & 32'h200000) | ((p + d) & 32'h1fffff);
	endfunction

	task automatic tbl(input int wr, input int mode);
		if (mode == 3)
			ptr = step(ptr, 1);
		if (wr != 0)
			hold[ptr & 63] = latch;
		else
			latch = mem[ptr & 255];
		if (mode == 1)
			ptr = step(ptr, 1);
		if (mode == 2)
			ptr = step(ptr, -1);
		bus(1'b1, 8'h10, 32'(wr + mode * 2));
	endtask

	task automatic tbl_run(input int wr);
		for (int i = 0; i < 12; i++)
		begin
			if (wr != 0)
				setl($urandom % 256);
			tbl(wr, i % 4);
			rd(8'h00, 32'(ptr));
			rd(8'h04, 32'(latch));
			check(core_stall, 1'b0);
		end
	endtask

	task automatic readback(input int row);
		setp(row * 64);
		for (int k = 0; k < 64; k++)
		begin
			tbl(0, 1);
			rd(8'h04, 32'(latch));
		end
	endtask

	task automatic flash_op(input logic erase);
		int base;
		base = ptr & 32'hc0;
		core.launch(erase, fsa_pkg::KEY_SECOND, 1'b1);
		for (int k = 0; k < 64; k++)
			mem[base + k] = erase ? 255 : (mem[base + k] & hold[k]);
		hold = '{default: 255};
		rd(8'h08, 32'h84);
		check(stall_len, LC);
	endtask

	initial
	begin
		presetn = 1'b0;
		warm_reset = 1'b0;
		seed = $urandom(32'h8899);
		hold = '{default: 255};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h0);
		check(core.last_err, 1'b0);
		rd(8'h14, 32'h0);
		check(core.last_err, 1'b1);
		$display("test reset done");
		for (int r = 0; r < 3; r++)
		begin
			setp(r * 64 + $urandom % 64);
			flash_op(1'b1);
			readback(r);
		end
		$display("test erase done");
		setp(70);
		tbl_run(1);
		flash_op(1'b0);
		readback(1);
		setp(70);
		tbl_run(0);
		setp(63);
		for (int k = 0; k < 64; k++)
		begin
			setl($urandom % 256);
			tbl(1, 3);
		end
		flash_op(1'b0);
		readback(1);
		$display("test program done");
		core.launch(1'b0, 8'h5a, 1'b1);
		rd(8'h08, 32'h8c);
		check(core_stall, 1'b0);
		bus(1'b1, 8'h08, 32'h0);
		core.launch(1'b0, fsa_pkg::KEY_SECOND, 1'b0);
		rd(8'h08, 32'h88);
		bus(1'b1, 8'h08, 32'h0);
		// correct unlock, but configuration selected or program memory not selected
		for (int s = 0; s < 2; s++)
		begin
			bus(1'b1, 8'h0c, 32'(fsa_pkg::KEY_FIRST));
			bus(1'b1, 8'h0c, 32'(fsa_pkg::KEY_SECOND));
			bus(1'b1, 8'h08, (s != 0) ? 32'h00000006 : 32'h000000c6);
			rd(8'h08, (s != 0) ? 32'h0000000c : 32'h000000cc);
			check(core_stall, 1'b0);
		end
		bus(1'b1, 8'h08, 32'h0);
		$display("test refusal done");
		setp(192);
		core.launch(1'b1, fsa_pkg::KEY_SECOND, 1'b1);
		repeat (5) @(posedge pclk);
		warm_reset <= 1'b1;
		@(posedge pclk);
		warm_reset <= 1'b0;
		bus(1'b0, 8'h08, 32'h0);
		check(q & 32'h8, 32'h8);
		check(core_stall, 1'b0);
		setp(5);
		flash_op(1'b0);
		readback(0);
		$display("test abort done");
		close_out();
	end
endmodule
